// *** tcas_consts.svh ***
`ifndef TCAS_CONSTS_SVH
`define TCAS_CONSTS_SVH

// Command codes, ROM stage
`define TCAS_CMD_READ_ROM     8'h33
`define TCAS_CMD_MATCH_ROM    8'h55
`define TCAS_CMD_SKIP_ROM     8'hCC
`define TCAS_CMD_SEARCH_ROM   8'hF0
`define TCAS_CMD_ALARM_SEARCH 8'hEC

// Command codes, memory and control stage
`define TCAS_CMD_CONVERT      8'h44
`define TCAS_CMD_READ_SP      8'hBE
`define TCAS_CMD_WRITE_SP     8'h4E
`define TCAS_CMD_COPY_SP      8'h48
`define TCAS_CMD_RECALL       8'hB8

// Scratchpad byte positions
`define TCAS_SP_TEMP_LSB      3'h0
`define TCAS_SP_TEMP_MSB      3'h1
`define TCAS_SP_HIGH          3'h2
`define TCAS_SP_LOW           3'h3
`define TCAS_SP_UNUSED0       3'h4
`define TCAS_SP_UNUSED1       3'h5
`define TCAS_SP_RESIDUAL      3'h6
`define TCAS_SP_SLOPE         3'h7
`define TCAS_SP_UNUSED_VAL    8'hFF

// Bit counts of the serial streams
`define TCAS_CMD_LAST_BIT     7'h07
`define TCAS_WR_FIRST_LAST    7'h07
`define TCAS_WR_SECOND_LAST   7'h0F
`define TCAS_ROM_CRC_AT       7'h38
`define TCAS_ROM_LAST_BIT     7'h3F
`define TCAS_SP_CRC_AT        7'h40
`define TCAS_SP_LAST_BIT      7'h47

// Temperature codes, half-degree units
`define TCAS_TEMP_MIN         9'h192
`define TCAS_TEMP_MAX         9'h0C8
`define TCAS_TEMP_RESET       9'h000
`define TCAS_TEMP_STEP        9'h001

// Counter model
`define TCAS_BASE_COUNT       8'h40
`define TCAS_SLOPE_BASE       8'h10
`define TCAS_SLOPE_STEP       8'h01
`define TCAS_COUNT_ONE        8'h01

// Nonvolatile trigger contents after manufacture
`define TCAS_NV_HIGH_INIT     8'h4B
`define TCAS_NV_LOW_INIT      8'h46

// CRC x^8 + x^5 + x^4 + 1, reflected taps
`define TCAS_CRC_TAPS         8'h0C
`define TCAS_CRC_INIT         8'h00

`endif

// *** tcas_pkg.sv ***
`default_nettype none
package tcas_pkg;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ROM_CMD  = 4'h1,
		ST_ROM_TX   = 4'h2,
		ST_MATCH    = 4'h3,
		ST_SEARCH   = 4'h4,
		ST_FUNC_CMD = 4'h5,
		ST_SP_TX    = 4'h6,
		ST_SP_WR    = 4'h7
	} tcas_state_e;

	typedef enum logic [1:0] {
		CV_IDLE      = 2'h0,
		CV_WAIT_GATE = 2'h1,
		CV_COUNT     = 2'h2
	} tcas_conv_e;

	typedef struct packed {
		logic [8:0] temp;
		logic [7:0] residual_gate_count;
		logic [7:0] counts_per_degree;
	} tcas_result_s;

	typedef struct packed {
		logic [7:0] high_alarm_limit;
		logic [7:0] low_alarm_limit;
	} tcas_limits_s;

endpackage : tcas_pkg
`default_nettype wire

// *** tcas_crc_step.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tcas_consts.svh"

module tcas_crc_step (
	input  wire logic [7:0] crc_in,
	input  wire logic       data_bit,
	output logic      [7:0] crc_out
);

	localparam logic [7:0] TAPS = `TCAS_CRC_TAPS;

	logic feedback;

	assign feedback = crc_in[0] ^ data_bit;
	assign crc_out[7] = feedback;

	genvar i;
	generate
		for (i = 0; i < 7; i++) begin : g_bit
			assign crc_out[i] = crc_in[i + 1] ^ (TAPS[i] & feedback);
		end
	endgenerate

endmodule : tcas_crc_step
`default_nettype wire

// *** tcas_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tcas_consts.svh"

module tcas_core #(
	parameter logic [7:0]  FAMILY_CODE   = 8'h5A,          // Arbitrary value
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123456789AB // Arbitrary value
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic link_reset,
	input  wire logic slot_done,
	input  wire logic slot_bit,
	output logic      reply_active,
	output logic      reply_bit,
	input  wire logic gate_osc_pin,
	input  wire logic count_osc_pin,
	output logic      converting,
	output logic      alarm_flag
);

	tcas_pkg::tcas_state_e  state;
	tcas_pkg::tcas_conv_e   conv_state;
	tcas_pkg::tcas_result_s result;
	tcas_pkg::tcas_limits_s limits;
	tcas_pkg::tcas_limits_s nv_limits;

	logic [1:0]  gate_sync;
	logic [1:0]  count_sync;
	logic        count_prev;
	logic        count_tick;
	logic        gate_open;

	logic [6:0]  bit_idx;
	logic [7:0]  shreg;
	logic [1:0]  search_phase;
	logic [7:0]  crc;
	logic [7:0]  crc_next;
	logic [63:0] sp_snap;
	logic [55:0] rom_data;
	logic        rom_bit;
	logic        sp_bit;
	logic        crc_bit;
	logic [7:0]  cmd_byte;
	logic        func_cmd_done;
	logic        start_conv;
	logic        do_copy;
	logic        do_recall;
	logic        wr_high;
	logic        wr_low;
	logic        conv_end;
	logic        next_reply_active;
	logic        next_reply_bit;

	logic [7:0]  down_cnt;
	logic [7:0]  slope_acc;
	logic [8:0]  temp_acc;
	logic [15:0] temp_word;

	// Oscillator pins come from another timing world
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			gate_sync  <= 2'h0;
			count_sync <= 2'h0;
			count_prev <= 1'b0;
		end else begin
			gate_sync  <= {gate_sync[0], gate_osc_pin};
			count_sync <= {count_sync[0], count_osc_pin};
			count_prev <= count_sync[1];
		end
	end

	assign count_tick = count_sync[1] & ~count_prev;
	assign gate_open  = gate_sync[1];

	assign rom_data = {SERIAL_NUMBER, FAMILY_CODE};
	assign rom_bit  = (bit_idx < `TCAS_ROM_CRC_AT) ? rom_data[bit_idx[5:0]] : crc[0];
	assign sp_bit   = (bit_idx < `TCAS_SP_CRC_AT) ? sp_snap[bit_idx[5:0]] : crc[0];
	assign crc_bit  = (state == tcas_pkg::ST_SP_TX) ? sp_bit : rom_bit;

	tcas_crc_step u_crc (
		.crc_in   (crc),
		.data_bit (crc_bit),
		.crc_out  (crc_next)
	);

	assign temp_word = {{7{result.temp[8]}}, result.temp};

	// Incoming bits enter at the top so the first lands in bit 0
	assign cmd_byte = {slot_bit, shreg[7:1]};

	assign func_cmd_done = slot_done && !link_reset && state == tcas_pkg::ST_FUNC_CMD
		&& bit_idx == `TCAS_CMD_LAST_BIT;
	assign start_conv = func_cmd_done && cmd_byte == `TCAS_CMD_CONVERT;
	assign do_copy    = func_cmd_done && cmd_byte == `TCAS_CMD_COPY_SP;
	assign do_recall  = func_cmd_done && cmd_byte == `TCAS_CMD_RECALL;
	assign wr_high = slot_done && !link_reset && state == tcas_pkg::ST_SP_WR
		&& bit_idx == `TCAS_WR_FIRST_LAST;
	assign wr_low  = slot_done && !link_reset && state == tcas_pkg::ST_SP_WR
		&& bit_idx == `TCAS_WR_SECOND_LAST;

	// Protocol sequencer
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state        <= tcas_pkg::ST_IDLE;
			bit_idx      <= 7'h00;
			shreg        <= 8'h00;
			search_phase <= 2'h0;
			crc          <= `TCAS_CRC_INIT;
			sp_snap      <= 64'h0;
		end else if (link_reset) begin
			state        <= tcas_pkg::ST_ROM_CMD;
			bit_idx      <= 7'h00;
			search_phase <= 2'h0;
			crc          <= `TCAS_CRC_INIT;
		end else if (slot_done) begin
			case (state)
				tcas_pkg::ST_ROM_CMD: begin
					shreg   <= cmd_byte;
					bit_idx <= bit_idx + 7'h01;
					if (bit_idx == `TCAS_CMD_LAST_BIT) begin
						bit_idx <= 7'h00;
						case (cmd_byte)
							`TCAS_CMD_READ_ROM:   state <= tcas_pkg::ST_ROM_TX;
							`TCAS_CMD_MATCH_ROM:  state <= tcas_pkg::ST_MATCH;
							`TCAS_CMD_SKIP_ROM:   state <= tcas_pkg::ST_FUNC_CMD;
							`TCAS_CMD_SEARCH_ROM: state <= tcas_pkg::ST_SEARCH;
							`TCAS_CMD_ALARM_SEARCH: begin
								state <= alarm_flag ? tcas_pkg::ST_SEARCH
									: tcas_pkg::ST_IDLE;
							end
							default: state <= tcas_pkg::ST_IDLE;
						endcase
					end
				end
				tcas_pkg::ST_ROM_TX: begin
					crc     <= crc_next;
					bit_idx <= bit_idx + 7'h01;
					if (bit_idx == `TCAS_ROM_LAST_BIT) begin
						state   <= tcas_pkg::ST_FUNC_CMD;
						bit_idx <= 7'h00;
					end
				end
				tcas_pkg::ST_MATCH: begin
					crc     <= crc_next;
					bit_idx <= bit_idx + 7'h01;
					if (slot_bit != rom_bit) begin
						state <= tcas_pkg::ST_IDLE;
					end else if (bit_idx == `TCAS_ROM_LAST_BIT) begin
						state   <= tcas_pkg::ST_FUNC_CMD;
						bit_idx <= 7'h00;
					end
				end
				tcas_pkg::ST_SEARCH: begin
					if (search_phase != 2'h2) begin
						search_phase <= search_phase + 2'h1;
					end else if (slot_bit != rom_bit) begin
						state <= tcas_pkg::ST_IDLE;
					end else begin
						search_phase <= 2'h0;
						crc          <= crc_next;
						bit_idx      <= bit_idx + 7'h01;
						if (bit_idx == `TCAS_ROM_LAST_BIT) begin
							state   <= tcas_pkg::ST_FUNC_CMD;
							bit_idx <= 7'h00;
						end
					end
				end
				tcas_pkg::ST_FUNC_CMD: begin
					shreg   <= cmd_byte;
					bit_idx <= bit_idx + 7'h01;
					if (bit_idx == `TCAS_CMD_LAST_BIT) begin
						bit_idx <= 7'h00;
						crc     <= `TCAS_CRC_INIT;
						case (cmd_byte)
							`TCAS_CMD_READ_SP: begin
								state   <= tcas_pkg::ST_SP_TX;
								sp_snap <= {result.counts_per_degree,
									result.residual_gate_count,
									`TCAS_SP_UNUSED_VAL, `TCAS_SP_UNUSED_VAL,
									limits.low_alarm_limit, limits.high_alarm_limit,
									temp_word};
							end
							`TCAS_CMD_WRITE_SP: state <= tcas_pkg::ST_SP_WR;
							default:            state <= tcas_pkg::ST_IDLE;
						endcase
					end
				end
				tcas_pkg::ST_SP_TX: begin
					crc     <= crc_next;
					bit_idx <= bit_idx + 7'h01;
					if (bit_idx == `TCAS_SP_LAST_BIT) begin
						state <= tcas_pkg::ST_IDLE;
					end
				end
				tcas_pkg::ST_SP_WR: begin
					shreg   <= cmd_byte;
					bit_idx <= bit_idx + 7'h01;
					if (bit_idx == `TCAS_WR_SECOND_LAST) begin
						state <= tcas_pkg::ST_IDLE;
					end
				end
				default: state <= tcas_pkg::ST_IDLE;
			endcase
		end
	end

	// Reply level for the next slot; 0 holds the line low
	always_comb begin
		next_reply_active = 1'b0;
		next_reply_bit    = 1'b1;
		case (state)
			tcas_pkg::ST_ROM_TX: begin
				next_reply_active = 1'b1;
				next_reply_bit    = rom_bit;
			end
			tcas_pkg::ST_SEARCH: begin
				next_reply_active = (search_phase != 2'h2);
				next_reply_bit    = (search_phase == 2'h1) ? ~rom_bit : rom_bit;
			end
			tcas_pkg::ST_SP_TX: begin
				next_reply_active = 1'b1;
				next_reply_bit    = sp_bit;
			end
			default: begin
				next_reply_active = 1'b0;
				next_reply_bit    = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reply_active <= 1'b0;
			reply_bit    <= 1'b1;
		end else begin
			reply_active <= next_reply_active;
			reply_bit    <= next_reply_bit;
		end
	end

	// Volatile trigger copies; reset loads the stored values
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			limits.high_alarm_limit <= `TCAS_NV_HIGH_INIT;
			limits.low_alarm_limit  <= `TCAS_NV_LOW_INIT;
		end else if (wr_high) begin
			limits.high_alarm_limit <= cmd_byte;
		end else if (wr_low) begin
			limits.low_alarm_limit <= cmd_byte;
		end else if (do_recall) begin
			limits <= nv_limits;
		end
	end

	// Nonvolatile triggers change only by copy or by reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			nv_limits.high_alarm_limit <= `TCAS_NV_HIGH_INIT;
			nv_limits.low_alarm_limit  <= `TCAS_NV_LOW_INIT;
		end else if (do_copy) begin
			nv_limits <= limits;
		end
	end

	// Gate-period measurement
	assign conv_end = (conv_state == tcas_pkg::CV_COUNT) && !gate_open;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			conv_state <= tcas_pkg::CV_IDLE;
			down_cnt   <= `TCAS_BASE_COUNT;
			slope_acc  <= `TCAS_SLOPE_BASE;
			temp_acc   <= `TCAS_TEMP_MIN;
		end else begin
			case (conv_state)
				tcas_pkg::CV_IDLE: begin
					if (start_conv) begin
						down_cnt   <= `TCAS_BASE_COUNT;
						temp_acc   <= `TCAS_TEMP_MIN;
						slope_acc  <= `TCAS_SLOPE_BASE;
						conv_state <= tcas_pkg::CV_WAIT_GATE;
					end
				end
				tcas_pkg::CV_WAIT_GATE: begin
					if (gate_open) begin
						conv_state <= tcas_pkg::CV_COUNT;
					end
				end
				tcas_pkg::CV_COUNT: begin
					if (!gate_open) begin
						conv_state <= tcas_pkg::CV_IDLE;
					end else if (count_tick) begin
						if (down_cnt == `TCAS_COUNT_ONE) begin
							if (temp_acc != `TCAS_TEMP_MAX) begin
								temp_acc <= temp_acc + `TCAS_TEMP_STEP;
							end
							down_cnt  <= slope_acc;
							slope_acc <= slope_acc + `TCAS_SLOPE_STEP;
						end else begin
							down_cnt <= down_cnt - `TCAS_COUNT_ONE;
						end
					end
				end
				default: conv_state <= tcas_pkg::CV_IDLE;
			endcase
		end
	end

	// Results land in the same cycle the conversion leaves its count state
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			result.temp                <= `TCAS_TEMP_RESET;
			result.residual_gate_count <= 8'h00;
			result.counts_per_degree   <= `TCAS_SLOPE_BASE;
		end else if (conv_end) begin
			result.temp                <= temp_acc;
			result.residual_gate_count <= down_cnt;
			result.counts_per_degree   <= slope_acc;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			alarm_flag <= 1'b0;
		end else if (conv_end) begin
			alarm_flag <= ($signed(temp_acc[8:1]) > $signed(nv_limits.high_alarm_limit))
				|| ($signed(temp_acc[8:1]) < $signed(nv_limits.low_alarm_limit));
		end
	end

	assign converting = (conv_state != tcas_pkg::CV_IDLE);

endmodule : tcas_core
`default_nettype wire

// *** tcas_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcas_master (
	input  wire logic core_clk,
	output logic      link_reset,
	output logic      slot_done,
	output logic      slot_bit,
	input  wire logic reply_active,
	input  wire logic reply_bit
);
	int gap = 0;
	initial begin
		link_reset = 1'b0;
		slot_done = 1'b0;
		slot_bit = 1'b1;
	end
	task automatic bus_reset;
		@(posedge core_clk);
		link_reset <= 1'b1;
		@(posedge core_clk);
		link_reset <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : bus_reset
	// Line level is the wired-AND of both parties
	task automatic slot(input logic b, output logic r);
		@(posedge core_clk);
		r = b & (~reply_active | reply_bit);
		slot_done <= 1'b1;
		slot_bit <= r;
		@(posedge core_clk);
		slot_done <= 1'b0;
		slot_bit <= ~r;
		repeat (3 + gap) @(posedge core_clk);
	endtask : slot
	task automatic xfer(input logic [7:0] d, output logic [7:0] r);
		for (int i = 0; i < 8; i++) slot(d[i], r[i]);
	endtask : xfer
endmodule : tcas_master
`default_nettype wire

// *** tcas_core_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcas_core_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic link_reset,
	input wire logic slot_done,
	input wire logic slot_bit,
	input wire logic reply_active,
	input wire logic reply_bit,
	input wire logic gate_osc_pin,
	input wire logic count_osc_pin,
	input wire logic converting,
	input wire logic alarm_flag
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	a_link_restart: assert property (link_reset ##1 (!slot_done)[*3] |-> !reply_active)
		else $error("reply active after bus reset");
	a_reply_stable: assert property ((!slot_done && !link_reset)[*4]
		|-> $stable(reply_bit) && $stable(reply_active))
		else $error("reply moved without a slot");
	a_reply_cause: assert property ($changed(reply_active) || $changed(reply_bit)
		|-> $past(slot_done, 2) || $past(slot_done, 3) || $past(link_reset, 2)
		|| $past(link_reset, 3))
		else $error("reply changed without cause");
	a_alarm_at_end: assert property ($changed(alarm_flag) |-> $fell(converting))
		else $error("alarm changed outside conversion end");
	a_conv_start: assert property ($rose(converting)
		|-> $past(slot_done) || $past(slot_done, 2))
		else $error("conversion began without a command");
	a_conv_end_cause: assert property ($fell(converting)
		|-> !$past(gate_osc_pin, 3))
		else $error("conversion ended with gate open");
	a_conv_end_bound: assert property ((converting && gate_osc_pin)[*4]
		##1 (!gate_osc_pin)[*5] |-> !converting)
		else $error("conversion outlived gate");
	a_conv_hold: assert property (converting && gate_osc_pin && $past(gate_osc_pin)
		&& $past(gate_osc_pin, 2) |=> converting)
		else $error("conversion stopped with gate open");
endmodule : tcas_core_chk
bind tcas_core tcas_core_chk tcas_core_chk_i (.core_clk, .resetn, .link_reset, .slot_done,
	.slot_bit, .reply_active, .reply_bit, .gate_osc_pin, .count_osc_pin, .converting,
	.alarm_flag);
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam logic [7:0]  FAM = 8'h3C;            // Arbitrary value
	localparam logic [47:0] SER = 48'hA5C31E079B42; // Arbitrary value
	logic        core_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        gate = 1'b0;
	logic        cnt_osc = 1'b0;
	logic        link_reset, slot_done, slot_bit, reply_active, reply_bit;
	logic        converting, alarm_flag, alarm;
	logic [7:0]  q, c, nv_h = 8'h4B, nv_l = 8'h46, sp_h = 8'h4B, sp_l = 8'h46;
	logic [7:0]  res = 8'h00, slope = 8'h10;
	logic [8:0]  temp = 9'h000;
	logic [63:0] rom;
	logic [7:0]  sp [9];
	int          num_errors = 0;
	int          n_compared = 0;
	always #2 core_clk = ~core_clk;
	tcas_core #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) tcas_core_i (.core_clk, .resetn,
		.link_reset, .slot_done, .slot_bit, .reply_active, .reply_bit, .gate_osc_pin(gate),
		.count_osc_pin(cnt_osc), .converting, .alarm_flag);
	tcas_master tcas_master_i (.core_clk, .link_reset, .slot_done, .slot_bit,
		.reply_active, .reply_bit);
	task automatic test_done;
		$display("Mismatches %0d of %0d compared", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [7:0] crc8(input logic [7:0] r, input logic [63:0] d, input int n);
		for (int i = 0; i < n; i++) r = {1'b0, r[7:1]} ^ (r[0] ^ d[i] ? 8'h8C : 8'h00);
		return r;
	endfunction : crc8
	task automatic cmd(input logic [7:0] rc, input logic [7:0] fc);
		tcas_master_i.bus_reset();
		tcas_master_i.xfer(rc, q);
		tcas_master_i.xfer(fc, q);
	endtask : cmd
	task automatic read_sp;
		cmd(8'hCC, 8'hBE);
		sp = '{temp[7:0], {8{temp[8]}}, sp_h, sp_l, 8'hFF, 8'hFF, res, slope, 8'h00};
		for (int i = 0; i < 8; i++) sp[8] = crc8(sp[8], 64'(sp[i]), 8);
		for (int i = 0; i < 9; i++) begin
			tcas_master_i.xfer(8'hFF, q);
			chk("scratchpad", sp[i], q);
		end
	endtask : read_sp
	task automatic sel_read(input logic [7:0] rc, input logic [63:0] m, input logic [7:0] e);
		tcas_master_i.bus_reset();
		tcas_master_i.xfer(rc, q);
		for (int i = 0; i < 8; i++) if (rc == 8'h55) tcas_master_i.xfer(m[8*i +: 8], q);
		tcas_master_i.xfer(8'hBE, q);
		tcas_master_i.xfer(8'hFF, q);
		chk("selected read", e, q);
	endtask : sel_read
	task automatic search(input logic [7:0] sc, input logic act);
		logic a, n;
		tcas_master_i.bus_reset();
		tcas_master_i.xfer(sc, q);
		for (int i = 0; i < 64; i++) begin
			tcas_master_i.slot(1'b1, a);
			tcas_master_i.slot(1'b1, n);
			tcas_master_i.slot(a, q[0]);
			chk("search", act ? 8'({rom[i], ~rom[i]}) : 8'h03, 8'({a, n}));
		end
	endtask : search
	task automatic wait_conv(input logic lvl);
		for (int i = 0; i < 60 && converting !== lvl; i++) @(posedge core_clk);
		chk("converting", 8'(lvl), 8'(converting));
		if (converting !== lvl) test_done();
	endtask : wait_conv
	task automatic convert(input int n);
		int cnt;
		cmd(8'hCC, 8'h44);
		wait_conv(1'b1);
		cnt = 64;
		temp = 9'h192;
		slope = 8'h10;
		gate <= 1'b1;
		repeat (n) begin
			repeat (3) @(posedge core_clk);
			cnt_osc <= 1'b1;
			repeat (3) @(posedge core_clk);
			cnt_osc <= 1'b0;
			if (cnt == 1) begin
				cnt = slope;
				slope++;
				if (temp != 9'h0C8) temp++;
			end
			else cnt--;
		end
		repeat (4) @(posedge core_clk);
		gate <= 1'b0;
		wait_conv(1'b0);
		res = cnt[7:0];
		alarm = $signed(temp[8:1]) > $signed(nv_h) || $signed(temp[8:1]) < $signed(nv_l);
		chk("alarm", 8'(alarm), 8'(alarm_flag));
	endtask : convert
	task automatic wr(input logic [7:0] h, input logic [7:0] l);
		cmd(8'hCC, 8'h4E);
		tcas_master_i.xfer(h, q);
		tcas_master_i.xfer(l, q);
		sp_h = h;
		sp_l = l;
		read_sp;
	endtask : wr
	initial begin
		void'($urandom(74));
		rom = {crc8(8'h00, {8'h00, SER, FAM}, 56), SER, FAM};
		c = 8'h00;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		read_sp;
		tcas_master_i.bus_reset();
		tcas_master_i.xfer(8'h33, q);
		for (int i = 0; i < 8; i++) begin
			tcas_master_i.xfer(8'hFF, q);
			chk("rom", rom[8*i +: 8], q);
			c = crc8(c, 64'(q), 8);
		end
		chk("rom check", 8'h00, c);
		sel_read(8'hBE, rom, 8'hFF);
		sel_read(8'h55, rom, temp[7:0]);
		sel_read(8'h55, rom ^ (64'h1 << $urandom_range(63)), 8'hFF);
		convert(64 + $urandom_range(99));
		read_sp;
		search(8'hEC, 1'b1);
		search(8'hF0, 1'b1);
		tcas_master_i.gap = 6;
		wr(8'($urandom), 8'($urandom));
		tcas_master_i.gap = 0;
		cmd(8'hCC, 8'hB8);
		sp_h = nv_h;
		sp_l = nv_l;
		read_sp;
		wr(8'h7F, 8'h80);
		cmd(8'hCC, 8'h48);
		nv_h = sp_h;
		nv_l = sp_l;
		convert(64);
		read_sp;
		search(8'hEC, 1'b0);
		test_done();
	end
endmodule : tb
`default_nettype wire
